// ==== inc/flash_cfg_pkg.sv ====
package flash_cfg_pkg;
  // ******************************
  // bus widths
  // ******************************
  localparam int ADDR_W = 22;
  localparam int HI_W = 6;
  localparam int DATA_W = 16;
  localparam int BANK_LSB = 20;
  // ******************************
  // command addresses and codes
  // ******************************
  localparam logic [11:0] UNLOCK_ADDR1 = 12'h0555;
  localparam logic [11:0] UNLOCK_ADDR2 = 12'h02aa;
  localparam logic [11:0] CFG_ADDR = 12'h0000;
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_CFG_READ = 8'hc6;
  localparam logic [7:0] CMD_CFG_LOAD = 8'hd0;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [7:0] CMD_AUTOSELECT = 8'h90;
  localparam logic [7:0] CMD_SECURE_ENTER = 8'h88;
  localparam logic [7:0] CMD_SECURE_EXIT = 8'h00;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  // ******************************
  // configuration word layout
  // ******************************
  localparam logic [15:0] CFG_RESET = 16'hadc8;
  localparam logic [15:0] CFG_WRITABLE = 16'hbd0f;
  localparam int READ_MODE_POS = 15;
  localparam int LATENCY_LSB = 11;
  localparam int READY_POL_POS = 10;
  localparam int READY_TIMING_POS = 8;
  localparam int WRAP_POS = 3;
  localparam int BURST_LEN_LSB = 0;
  localparam logic [2:0] BURST_CONT = 3'h0;
  localparam logic [2:0] BURST_LIN8 = 3'h2;
  localparam logic [2:0] BURST_LIN16 = 3'h3;
  localparam logic [3:0] LATENCY_BASE = 4'h2;
  // ******************************
  // read regions
  // ******************************
  localparam logic [1:0] REGION_ARRAY = 2'h0;
  localparam logic [1:0] REGION_SERIAL = 2'h1;
  localparam logic [1:0] REGION_AUTOSELECT = 2'h2;
endpackage : flash_cfg_pkg

// ==== src/flash_burst_config_command_ctrl.sv ====
// Overview of operation
// RQ1: unlock, C6h at 555h, read 000h returns config
// RQ2: after config readback, reset needed to resume
// RQ3: unlock, D0h at 555h, config written at 000h
// RQ4: config changes refused while any bank busy
// RQ5: reset starts async; read mode 0 sync, 1 async
// RQ6: latency codes 1-7 give edges 3-9
// RQ7: reset latency default gives seven cycles
// RQ8: host should write latency even when default
// RQ9: host uses latency code 100 at 66 MHz
// RQ10: burst length continuous, 8 or 16 word
// RQ11: continuous burst rolls over at top address
// RQ12: linear burst wraps within aligned group
// RQ13: wrap bit default 1, zero disables wrap
// RQ14: continuous mode forces wrap bit to read 1
// RQ15: ready with data or one cycle early
// RQ16: ready polarity high or low, idle asserts
// RQ17: reset returns banks to read, address ignored
// RQ18: reset aborts pending sequence, ignored when busy
// RQ19: reset keeps erase-suspended bank in suspend read
// RQ20: autoselect persists until reset
// RQ21: time limit flag lets reset return banks
// RQ22: buffer abort flag blocks ordinary reset
// RQ23: unlock plus bank address enters autoselect
// RQ24: autoselect only when no bank is busy
// RQ25: secure region entered and exited by sequences
// RQ26: unlock is AAh at 555h then 55h at 2AAh
// RQ27: wrong cycle abandons sequence, back to read
`timescale 1ns/1ps
`default_nettype none
module flash_burst_config_command_ctrl
  import flash_cfg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_burst_clk,
  input wire logic i_chip_enable_b,
  input wire logic i_address_valid_strobe_b,
  input wire logic i_write_strobe_b,
  input wire logic i_output_enable_b,
  input wire logic [DATA_W-1:0] i_adq,
  input wire logic [HI_W-1:0] i_addr_hi,
  input wire logic [3:0] i_bank_busy,
  input wire logic [3:0] i_erase_suspended,
  input wire logic i_time_limit_flag,
  input wire logic i_buffer_abort_flag,
  input wire logic [DATA_W-1:0] i_array_data,
  input wire logic [DATA_W-1:0] i_burst_data,
  output logic [DATA_W-1:0] o_adq,
  output logic o_adq_oe,
  output logic [ADDR_W-1:0] o_array_addr,
  output logic [1:0] o_read_region,
  output logic [DATA_W-1:0] o_burst_adq,
  output logic o_burst_adq_oe,
  output logic [ADDR_W-1:0] o_burst_addr,
  output logic o_ready,
  output logic [DATA_W-1:0] o_config,
  output logic [3:0] o_bank_autoselect,
  output logic [3:0] o_bank_suspend_read,
  output logic o_secure_region,
  output logic o_program_req,
  output logic o_erase_req,
  output logic [ADDR_W-1:0] o_cmd_addr,
  output logic [DATA_W-1:0] o_cmd_data
);
  // ******************************
  // pin synchronisers, core domain
  // ******************************
  localparam int PIN_W = 4 + DATA_W + HI_W;
  logic [PIN_W-1:0] pin_meta_reg;
  logic [PIN_W-1:0] pin_sync_reg;
  logic [PIN_W-1:0] pin_prev_reg;
  logic ce_b, avd_b, we_b, oe_b;
  logic [DATA_W-1:0] bus;
  logic [HI_W-1:0] bus_hi;
  logic avd_rise, we_rise;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_meta_reg <= '1;
      pin_sync_reg <= '1;
      pin_prev_reg <= '1;
    end else begin
      pin_meta_reg <= {i_chip_enable_b, i_address_valid_strobe_b, i_write_strobe_b,
                       i_output_enable_b, i_adq, i_addr_hi};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  assign {ce_b, avd_b, we_b, oe_b, bus, bus_hi} = pin_sync_reg;
  assign avd_rise = avd_b && !pin_prev_reg[PIN_W-2] && !ce_b;
  assign we_rise = we_b && !pin_prev_reg[PIN_W-3] && !ce_b;

  // ******************************
  // address latch
  // ******************************
  logic [ADDR_W-1:0] addr_reg;
  logic [1:0] bank;
  logic busy_any;
  logic [7:0] cmd;
  logic [11:0] cmd_addr;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      addr_reg <= '0;
    end else if (avd_rise) begin
      addr_reg <= {bus_hi, bus};
    end
  end

  assign bank = addr_reg[BANK_LSB+1:BANK_LSB];
  assign busy_any = |i_bank_busy;
  assign cmd = bus[7:0];
  assign cmd_addr = addr_reg[11:0];

  // ******************************
  // command sequencer
  // ******************************
  typedef enum logic [3:0] {
    st_idle, st_unlock1, st_unlock2, st_cfg_load, st_cfg_hold, st_prog_data,
    st_erase_setup, st_erase_unlock1, st_erase_unlock2, st_exit_confirm
  } cmd_state_e;

  cmd_state_e state_reg;
  logic reset_ok;
  logic [DATA_W-1:0] cfg_reg;
  logic [DATA_W-1:0] cfg_view;
  logic secure_reg;
  logic [3:0] autosel_reg;

  // an aborted embedded operation may be reset only on a time-out; buffer abort needs its own sequence
  assign reset_ok = (!(|i_bank_busy[3:0]) || i_time_limit_flag) && !i_buffer_abort_flag; // RQ18 RQ21 RQ22

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= st_idle;
    end else if (we_rise) begin
      if (cmd == CMD_RESET && state_reg != st_exit_confirm && state_reg != st_cfg_load) begin
        if (reset_ok) begin
          state_reg <= st_idle; // RQ2 RQ17 RQ18
        end
      end else begin
        unique case (state_reg)
          st_idle: begin
            state_reg <= (cmd == CMD_UNLOCK1 && cmd_addr == UNLOCK_ADDR1) ? st_unlock1 : st_idle; // RQ26
          end
          st_unlock1: begin
            state_reg <= (cmd == CMD_UNLOCK2 && cmd_addr == UNLOCK_ADDR2) ? st_unlock2 : st_idle; // RQ26 RQ27
          end
          st_unlock2: begin
            if (cmd == CMD_CFG_READ && cmd_addr == UNLOCK_ADDR1) begin
              state_reg <= st_cfg_hold; // RQ1
            end else if (cmd == CMD_CFG_LOAD && cmd_addr == UNLOCK_ADDR1 && !busy_any) begin
              state_reg <= st_cfg_load; // RQ3 RQ4
            end else if (cmd == CMD_AUTOSELECT && secure_reg) begin
              state_reg <= st_exit_confirm; // RQ25
            end else if (cmd == CMD_PROGRAM) begin
              state_reg <= st_prog_data;
            end else if (cmd == CMD_ERASE_SETUP) begin
              state_reg <= st_erase_setup;
            end else begin
              state_reg <= st_idle; // RQ27
            end
          end
          st_cfg_load: begin
            state_reg <= (cmd_addr == CFG_ADDR) ? st_cfg_hold : st_idle; // RQ3 RQ27
          end
          st_cfg_hold: begin
            state_reg <= st_cfg_hold; // RQ2
          end
          st_erase_setup: begin
            state_reg <= (cmd == CMD_UNLOCK1 && cmd_addr == UNLOCK_ADDR1) ? st_erase_unlock1 : st_idle;
          end
          st_erase_unlock1: begin
            state_reg <= (cmd == CMD_UNLOCK2 && cmd_addr == UNLOCK_ADDR2) ? st_erase_unlock2 : st_idle;
          end
          st_prog_data, st_erase_unlock2, st_exit_confirm: begin
            state_reg <= st_idle;
          end
        endcase
      end
    end
  end

  // config load; a load that arrives while an operation runs is dropped
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_reg <= CFG_RESET; // RQ5 RQ7 RQ10 RQ13 RQ15 RQ16
    end else if (we_rise && state_reg == st_cfg_load && cmd_addr == CFG_ADDR && !busy_any) begin
      cfg_reg <= (bus & CFG_WRITABLE) | (CFG_RESET & ~CFG_WRITABLE); // RQ3 RQ4
    end
  end

  always_comb begin
    cfg_view = cfg_reg;
    if (cfg_reg[BURST_LEN_LSB+2:BURST_LEN_LSB] == BURST_CONT) begin
      cfg_view[WRAP_POS] = 1'b1; // RQ14
    end
  end

  // secure region and autoselect
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      secure_reg <= 1'b0;
    end else if (we_rise && state_reg == st_unlock2 && cmd == CMD_SECURE_ENTER
                 && cmd_addr == UNLOCK_ADDR1 && !busy_any) begin
      secure_reg <= 1'b1; // RQ25
    end else if (we_rise && state_reg == st_exit_confirm && cmd == CMD_SECURE_EXIT) begin
      secure_reg <= 1'b0; // RQ25
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      autosel_reg <= '0;
    end else if (we_rise && cmd == CMD_RESET && state_reg != st_exit_confirm
                 && state_reg != st_cfg_load && reset_ok) begin
      autosel_reg <= '0; // RQ20
    end else if (we_rise && state_reg == st_unlock2 && cmd == CMD_AUTOSELECT
                 && !secure_reg && !busy_any) begin
      autosel_reg[bank] <= 1'b1; // RQ23 RQ24
    end
  end

  // program and erase requests leave to the embedded engine
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_program_req <= 1'b0;
      o_erase_req <= 1'b0;
      o_cmd_addr <= '0;
      o_cmd_data <= '0;
    end else begin
      o_program_req <= we_rise && state_reg == st_prog_data && cmd != CMD_RESET;
      o_erase_req <= we_rise && state_reg == st_erase_unlock2
                     && (cmd == CMD_CHIP_ERASE || cmd == CMD_SECTOR_ERASE);
      if (we_rise) begin
        o_cmd_addr <= addr_reg;
        o_cmd_data <= bus;
      end
    end
  end

  // ******************************
  // asynchronous read path
  // ******************************
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_adq <= '0;
      o_adq_oe <= 1'b0;
      o_array_addr <= '0;
      o_read_region <= REGION_ARRAY;
      o_config <= CFG_RESET;
      o_bank_autoselect <= '0;
      o_bank_suspend_read <= '0;
      o_secure_region <= 1'b0;
    end else begin
      o_adq_oe <= !ce_b && !oe_b && cfg_reg[READ_MODE_POS]; // RQ5
      if (state_reg == st_cfg_hold && addr_reg == '0) begin
        o_adq <= cfg_view; // RQ1
      end else begin
        o_adq <= i_array_data;
      end
      o_array_addr <= addr_reg;
      if (autosel_reg[bank]) begin
        o_read_region <= REGION_AUTOSELECT; // RQ23
      end else if (secure_reg && !busy_any) begin
        o_read_region <= REGION_SERIAL; // RQ25
      end else begin
        o_read_region <= REGION_ARRAY;
      end
      o_config <= cfg_view;
      o_bank_autoselect <= autosel_reg;
      o_bank_suspend_read <= i_erase_suspended & ~autosel_reg; // RQ19 RQ20
      o_secure_region <= secure_reg;
    end
  end

  // ******************************
  // burst engine, link domain
  // ******************************
  // config is quasi-static: it only changes through the command path; nothing here blocks a load mid-burst
  logic [DATA_W-1:0] cfg_meta_reg;
  logic [DATA_W-1:0] cfg_link_reg;
  logic active_reg;
  logic valid_reg;
  logic [3:0] cnt_reg, first_edge;
  logic [2:0] blen;
  logic wrap, start, ready_next;
  logic [ADDR_W-1:0] addr_inc;

  always_ff @(posedge i_burst_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_meta_reg <= CFG_RESET;
      cfg_link_reg <= CFG_RESET;
    end else begin
      cfg_meta_reg <= o_config;
      cfg_link_reg <= cfg_meta_reg;
    end
  end

  assign first_edge = {1'b0, cfg_link_reg[LATENCY_LSB+2:LATENCY_LSB]} + LATENCY_BASE; // RQ6
  assign blen = cfg_link_reg[BURST_LEN_LSB+2:BURST_LEN_LSB];
  assign wrap = cfg_link_reg[WRAP_POS]; // RQ13
  // bus pins are synchronous to the burst clock by protocol, so they are sampled directly
  assign start = !i_address_valid_strobe_b && !i_chip_enable_b && !cfg_link_reg[READ_MODE_POS];

  always_comb begin
    addr_inc = o_burst_addr + 22'h00_0001; // RQ11
    if (wrap && blen == BURST_LIN8) begin
      addr_inc = {o_burst_addr[ADDR_W-1:3], 3'(o_burst_addr[2:0] + 3'h1)}; // RQ12
    end else if (wrap && blen == BURST_LIN16) begin
      addr_inc = {o_burst_addr[ADDR_W-1:4], 4'(o_burst_addr[3:0] + 4'h1)}; // RQ12
    end
  end

  always_ff @(posedge i_burst_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      active_reg <= 1'b0;
      valid_reg <= 1'b0;
      cnt_reg <= '0;
      o_burst_addr <= '0;
      o_burst_adq <= '0;
    end else if (start) begin
      active_reg <= 1'b1;
      valid_reg <= 1'b0;
      cnt_reg <= 4'h1;
      o_burst_addr <= {i_addr_hi, i_adq};
    end else if (active_reg && i_chip_enable_b) begin
      active_reg <= 1'b0;
      valid_reg <= 1'b0;
    end else if (active_reg) begin
      if (valid_reg || cnt_reg == first_edge - 4'h1) begin
        valid_reg <= 1'b1; // RQ6
        o_burst_adq <= i_burst_data;
        o_burst_addr <= addr_inc;
      end else begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end

  // ready is a registered copy of the next data state, so early ready needs one edge less
  always_comb begin
    if (start) begin
      ready_next = 1'b0;
    end else if (active_reg && !i_chip_enable_b) begin
      ready_next = valid_reg || cnt_reg == first_edge - 4'h1
                   || (!cfg_link_reg[READY_TIMING_POS] && cnt_reg == first_edge - 4'h2); // RQ15
    end else begin
      ready_next = 1'b1; // RQ16
    end
  end

  always_ff @(posedge i_burst_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ready <= 1'b1;
      o_burst_adq_oe <= 1'b0;
    end else begin
      o_ready <= cfg_link_reg[READY_POL_POS] ? ready_next : !ready_next; // RQ16
      o_burst_adq_oe <= !start && active_reg && !i_chip_enable_b && !i_output_enable_b
                        && (valid_reg || cnt_reg == first_edge - 4'h1);
    end
  end
endmodule : flash_burst_config_command_ctrl
`default_nettype wire

// ==== sim/flash_burst_config_command_ctrl_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module flash_ctrl_monitor
  import flash_cfg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_burst_clk,
  input wire logic i_chip_enable_b,
  input wire logic i_address_valid_strobe_b,
  input wire logic [3:0] i_bank_busy,
  input wire logic o_burst_adq_oe,
  input wire logic [ADDR_W-1:0] o_burst_addr,
  input wire logic o_ready,
  input wire logic [DATA_W-1:0] o_config
);
  // ********
  // burst edge counter, restarted at the latch edge
  // ********
  logic [3:0] edge_reg;
  always_ff @(posedge i_burst_clk or negedge i_rst_b) begin
    if (!i_rst_b) edge_reg <= 4'h0;
    else if (!i_address_valid_strobe_b && !i_chip_enable_b) edge_reg <= 4'h0;
    else if (edge_reg != 4'hf) edge_reg <= edge_reg + 4'h1;
  end
  sequence s_first_beat;
    $rose(o_burst_adq_oe);
  endsequence
  sequence s_beat_run;
    o_burst_adq_oe && $past(o_burst_adq_oe);
  endsequence
  a_first_data_edge: assert property (@(posedge i_burst_clk) disable iff (!i_rst_b)
    s_first_beat |-> edge_reg == {1'b0, o_config[13:11]} + 4'h1) else $error("first beat late");
  a_ready_lead_time: assert property (@(posedge i_burst_clk) disable iff (!i_rst_b)
    s_first_beat |-> ($past(o_ready) == o_config[10]) == !o_config[8])
    else $error("ready lead wrong");
  a_cont_addr_step: assert property (@(posedge i_burst_clk) disable iff (!i_rst_b)
    s_beat_run and o_config[2:0] == BURST_CONT |-> o_burst_addr == $past(o_burst_addr) + 22'h1)
    else $error("continuous step wrong");
  a_lin8_group_wrap: assert property (@(posedge i_burst_clk) disable iff (!i_rst_b)
    s_beat_run and o_config[3:0] == {1'b1, BURST_LIN8} |->
    o_burst_addr == {$past(o_burst_addr[21:3]), $past(o_burst_addr[2:0]) + 3'h1})
    else $error("linear wrap wrong");
  a_busy_cfg_frozen: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (|i_bank_busy) [*8] |-> $stable(o_config)) else $error("config changed while busy");
  a_reserved_bits_fixed: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (o_config & ~CFG_WRITABLE) == (CFG_RESET & ~CFG_WRITABLE)) else $error("reserved bits moved");
  a_cont_wrap_forced: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_config[2:0] == BURST_CONT |-> o_config[3]) else $error("wrap bit not forced");
  a_reset_cfg_value: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !$past(i_rst_b) |-> o_config == CFG_RESET) else $error("reset config wrong");
endmodule : flash_ctrl_monitor
bind flash_burst_config_command_ctrl flash_ctrl_monitor u_mon (.*);
`default_nettype wire

// ==== sim/host_bus_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  input wire logic i_clk,
  input wire logic [15:0] i_adq,
  input wire logic i_adq_oe,
  output logic o_burst_clk,
  output logic o_chip_enable_b,
  output logic o_address_valid_strobe_b,
  output logic o_write_strobe_b,
  output logic o_output_enable_b,
  output logic [15:0] o_adq,
  output logic [5:0] o_addr_hi
);
  logic run;
  initial begin
    run = 1'b0;
    o_burst_clk = 1'b0;
    o_chip_enable_b = 1'b1;
    o_address_valid_strobe_b = 1'b1;
    o_write_strobe_b = 1'b1;
    o_output_enable_b = 1'b1;
    o_adq = 16'h0000;
    o_addr_hi = 6'h00;
  end
  // link clock stands still outside burst frames
  always #16 o_burst_clk = run ? ~o_burst_clk : 1'b0;
  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clk);
  endtask : wait_clk
  task automatic bus(input logic wr_en, input logic [21:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    @(posedge i_clk);
    o_chip_enable_b <= 1'b0;
    o_address_valid_strobe_b <= 1'b0;
    o_adq <= a[15:0];
    o_addr_hi <= a[21:16];
    wait_clk(4);
    o_address_valid_strobe_b <= 1'b1;
    wait_clk(4);
    if (wr_en) begin
      o_adq <= d;
      o_write_strobe_b <= 1'b0;
      wait_clk(4);
      o_write_strobe_b <= 1'b1;
    end else begin
      // released bus never keeps the old value
      o_adq <= ~a[15:0];
      o_output_enable_b <= 1'b0;
      repeat (20) if (i_adq_oe !== 1'b1) @(negedge i_clk);
      q = i_adq;
      @(posedge i_clk);
      o_output_enable_b <= 1'b1;
    end
    wait_clk(4);
    o_chip_enable_b <= 1'b1;
    o_adq <= ~o_adq;
    wait_clk(4);
  endtask : bus
  task automatic wr(input logic [21:0] a, input logic [15:0] d);
    logic [15:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic unlock();
    wr(22'h00_0555, 16'h00aa);
    wr(22'h00_02aa, 16'h0055);
  endtask : unlock
  task automatic burst_start(input logic [21:0] a);
    run = 1'b1;
    // idle edges first, so a new config has crossed to the link side
    repeat (3) @(posedge o_burst_clk);
    o_chip_enable_b <= 1'b0;
    o_output_enable_b <= 1'b0;
    o_address_valid_strobe_b <= 1'b0;
    o_adq <= a[15:0];
    o_addr_hi <= a[21:16];
    @(posedge o_burst_clk);
    o_address_valid_strobe_b <= 1'b1;
    o_adq <= ~a[15:0];
  endtask : burst_start
  task automatic burst_stop();
    @(posedge o_burst_clk);
    o_chip_enable_b <= 1'b1;
    o_output_enable_b <= 1'b1;
    @(posedge o_burst_clk);
    run = 1'b0;
  endtask : burst_stop
endmodule : host_bus_model
`default_nettype wire

// ==== sim/flash_burst_config_command_ctrl_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module flash_burst_config_command_ctrl_tb
  import flash_cfg_pkg::*;
;
  logic i_clk = 1'b0, i_rst_b, i_burst_clk, i_chip_enable_b, i_address_valid_strobe_b;
  logic i_write_strobe_b, i_output_enable_b, i_time_limit_flag, i_buffer_abort_flag;
  logic [15:0] i_adq, i_array_data, i_burst_data, o_adq, o_burst_adq, o_config, o_cmd_data;
  logic [5:0] i_addr_hi;
  logic [3:0] i_bank_busy, i_erase_suspended, o_bank_autoselect, o_bank_suspend_read;
  logic [21:0] o_array_addr, o_burst_addr, o_cmd_addr;
  logic [1:0] o_read_region;
  logic o_adq_oe, o_burst_adq_oe, o_ready, o_secure_region, o_program_req, o_erase_req;
  int errors, compares, seed, k, n;
  logic [15:0] q, w, cfg;
  logic [21:0] preqs = '0, ereqs = '0;
  flash_burst_config_command_ctrl DUT (.*);
  host_bus_model h (.i_clk(i_clk), .i_adq(o_adq), .i_adq_oe(o_adq_oe),
    .o_burst_clk(i_burst_clk), .o_chip_enable_b(i_chip_enable_b),
    .o_address_valid_strobe_b(i_address_valid_strobe_b),
    .o_write_strobe_b(i_write_strobe_b), .o_output_enable_b(i_output_enable_b),
    .o_adq(i_adq), .o_addr_hi(i_addr_hi));
  // array contents derived from address so every beat is distinct
  assign i_array_data = o_array_addr[15:0] ^ 16'ha5c3;
  assign i_burst_data = o_burst_addr[15:0] ^ 16'h5a5a;
  // request pulses stand one cycle, so they are counted here
  always @(posedge i_clk) begin
    if (o_program_req === 1'b1) preqs <= preqs + 22'h00_0001;
    if (o_erase_req === 1'b1) ereqs <= ereqs + 22'h00_0001;
  end
  always #5 i_clk = ~i_clk;
  task automatic chk(input string s, input logic [21:0] e, input logic [21:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  function automatic logic [15:0] eff(input logic [15:0] v);
    eff = (v & CFG_WRITABLE) | (CFG_RESET & ~CFG_WRITABLE);
    if (v[2:0] == BURST_CONT) eff[WRAP_POS] = 1'b1;
  endfunction : eff
  function automatic logic [15:0] beat(input logic [21:0] s, input logic [2:0] len, input int b);
    logic [21:0] t;
    t = s + 22'(b);
    if (len == BURST_LIN8) t[21:3] = s[21:3];
    if (len == BURST_LIN16) t[21:4] = s[21:4];
    beat = t[15:0] ^ 16'h5a5a;
  endfunction : beat
  task automatic load(input logic [15:0] v);
    h.unlock();
    h.wr(22'h00_0555, {8'h00, CMD_CFG_LOAD});
    h.wr(22'h00_0000, v);
    h.wr(22'h00_0000, {8'h00, CMD_RESET});
  endtask : load
  task automatic rdcfg(input logic [15:0] e);
    h.unlock();
    h.wr(22'h00_0555, {8'h00, CMD_CFG_READ});
    h.bus(1'b0, 22'h00_0000, 16'h0000, q);
    chk("config read", e, q);
    h.wr(22'h00_0000, {8'h00, CMD_RESET});
    h.bus(1'b0, 22'h00_0000, 16'h0000, q);
    chk("array read", 16'ha5c3, q);
  endtask : rdcfg
  task automatic burst(input logic [2:0] len, input logic [21:0] s);
    logic [2:0] code;
    logic pol;
    logic rt;
    int lat;
    code = 3'($unsigned($random(seed)) % 7 + 1);
    if (len == BURST_LIN16) code = 3'h4;
    pol = 1'($random(seed));
    rt = 1'($random(seed));
    lat = code + 2;
    load({2'b00, code, pol, 1'b0, rt, 4'hc, 1'b1, len});
    h.wait_clk(10);
    h.burst_start(s);
    for (k = 1; k < lat + 6; k++) begin
      @(negedge i_burst_clk);
      if (k == lat - 1) chk("early data", 1'b0, o_burst_adq_oe);
      if (k == lat - 1) chk("early ready", rt ? !pol : pol, o_ready);
      if (k == lat) chk("ready", pol, o_ready);
      if (k == lat) chk("burst oe", 1'b1, o_burst_adq_oe);
      if (k == lat) chk("async off", 1'b0, o_adq_oe);
      if (k >= lat) chk("burst data", beat(s, len, k - lat), o_burst_adq);
    end
    h.burst_stop();
  endtask : burst
  task automatic final_report();
    if (errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  initial begin
    #200_000;
    errors++;
    final_report();
  end
  initial begin
    seed = 32'h9559_5b1e;
    errors = 0;
    compares = 0;
    i_rst_b = 1'b0;
    i_bank_busy = 4'h0;
    i_erase_suspended = 4'h0;
    i_time_limit_flag = 1'b0;
    i_buffer_abort_flag = 1'b0;
    repeat (8) @(posedge i_clk);
    i_rst_b <= 1'b1;
    h.wait_clk(6);
    chk("reset config", CFG_RESET, o_config);
    rdcfg(CFG_RESET);
    for (n = 0; n < 5; n++) begin
      w = 16'($random(seed));
      w[15] = 1'b1;
      if (n == 0) w[3:0] = 4'h0;
      load(w);
      cfg = eff(w);
      chk("config", cfg, o_config);
      rdcfg(cfg);
    end
    i_bank_busy <= 4'h2;
    load(~cfg);
    chk("busy config", cfg, o_config);
    h.unlock();
    h.wr(22'h00_0555, 16'h0090);
    chk("busy autoselect", 4'h0, o_bank_autoselect);
    i_bank_busy <= 4'h0;
    i_erase_suspended <= 4'h8;
    for (n = 0; n < 4; n++) begin
      h.unlock();
      h.wr({n[1:0], 20'h0_0555}, 16'h0090);
      chk("autoselect", 4'h1 << n, o_bank_autoselect);
      chk("region", REGION_AUTOSELECT, o_read_region);
      h.wr(22'($random(seed)), 16'h00f0);
      chk("suspend read", 4'h8, o_bank_suspend_read);
      chk("autoselect off", 4'h0, o_bank_autoselect);
    end
    h.unlock();
    h.wr(22'h00_0555, 16'h0090);
    i_bank_busy <= 4'h2;
    i_buffer_abort_flag <= 1'b1;
    h.wr(22'h00_0000, 16'h00f0);
    chk("abort flag", 4'h1, o_bank_autoselect);
    i_buffer_abort_flag <= 1'b0;
    i_time_limit_flag <= 1'b1;
    h.wr(22'h00_0000, 16'h00f0);
    chk("limit flag", 4'h0, o_bank_autoselect);
    i_time_limit_flag <= 1'b0;
    i_bank_busy <= 4'h0;
    h.unlock();
    h.wr(22'h00_0555, 16'h0088);
    chk("secure on", 1'b1, o_secure_region);
    chk("serial region", REGION_SERIAL, o_read_region);
    h.unlock();
    h.wr(22'h00_0555, 16'h0090);
    h.wr(22'h00_0000, 16'h0000);
    chk("secure off", 1'b0, o_secure_region);
    h.wr(22'h00_0555, 16'h00aa);
    h.wr(22'h00_02ab, 16'h0055);
    h.wr(22'h00_0555, 16'h0088);
    chk("bad unlock", 1'b0, o_secure_region);
    h.unlock();
    h.wr(22'h00_0555, {8'h00, CMD_PROGRAM});
    h.wr(22'h00_0000, {8'h00, CMD_RESET});
    h.wr(22'h15_4321, 16'hbeef);
    chk("aborted program", 22'h00_0000, preqs);
    chk("suspend kept", 4'h8, o_bank_suspend_read);
    h.unlock();
    h.wr(22'h00_0555, {8'h00, CMD_PROGRAM});
    h.wr(22'h15_4321, 16'hbeef);
    chk("program req", 22'h00_0001, preqs);
    chk("program addr", 22'h15_4321, o_cmd_addr);
    chk("program data", 16'hbeef, o_cmd_data);
    h.unlock();
    h.wr(22'h00_0555, {8'h00, CMD_ERASE_SETUP});
    h.unlock();
    h.wr(22'h2a_0000, {8'h00, CMD_SECTOR_ERASE});
    chk("erase req", 22'h00_0001, ereqs);
    burst(BURST_CONT, 22'h3f_fffe);
    burst(BURST_LIN8, {18'($random(seed)), 4'he});
    burst(BURST_LIN16, {18'($random(seed)), 4'he});
    final_report();
  end
endmodule : flash_burst_config_command_ctrl_tb
`default_nettype wire
